// ==== include/supervisor_pkg.sv ====
// shared constants and carriers for the global supervisor
// assumes a single 200 MHz clock domain
package supervisor_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned DEBOUNCE_SHORT_US = 500;
    localparam int unsigned DEBOUNCE_LONG_MS = 30;
    localparam int unsigned HOLD_SHORT_S = 4;
    localparam int unsigned HOLD_LONG_S = 8;
    localparam int unsigned RELEASE_DELAY_US = 100;
    localparam int unsigned ASSERT_LEAD_US = 100;
    localparam int unsigned DEBOUNCE_SHORT_CYC = DEBOUNCE_SHORT_US * CLK_MHZ;
    localparam int unsigned DEBOUNCE_LONG_CYC = DEBOUNCE_LONG_MS * 1000 * CLK_MHZ;
    localparam longint unsigned HOLD_SHORT_CYC = 64'(HOLD_SHORT_S) * 1000000 * CLK_MHZ;
    localparam longint unsigned HOLD_LONG_CYC = 64'(HOLD_LONG_S) * 1000000 * CLK_MHZ;
    localparam int unsigned RELEASE_DELAY_CYC = RELEASE_DELAY_US * CLK_MHZ;
    localparam int unsigned ASSERT_LEAD_CYC = ASSERT_LEAD_US * CLK_MHZ;

    // ****************************************
    // on-key behaviour codes and resets
    // ****************************************
    localparam logic [1:0] BEHAVIOUR_PUSH = 2'h0;
    localparam logic [1:0] BEHAVIOUR_SLIDE = 2'h1;
    localparam logic [1:0] BEHAVIOUR_LOGIC = 2'h2;
    localparam logic [1:0] BEHAVIOUR_RESET = 2'h0;
    // arbitrary option code
    localparam logic [4:0] CHIP_OPTION_DEFAULT = 5'h0b;

    // ****************************************
    // interrupt bit positions
    // ****************************************
    localparam int unsigned INT_COUNT = 4;
    localparam int unsigned INT_ALARM1 = 0;
    localparam int unsigned INT_ALARM2 = 1;
    localparam int unsigned INT_KEY_RISE = 2;
    localparam int unsigned INT_KEY_FALL = 3;
    localparam logic [3:0] INT_MASK_RESET = 4'hf;

    typedef struct packed {
        logic alarm1_hot;
        logic alarm2_hot;
        logic shutdown_hot;
    } thermal_s;

    typedef struct packed {
        logic por;
        logic undervoltage;
        logic overvoltage;
    } supply_s;

    typedef enum logic [4:0] {
        ST_SHUTDOWN = 5'h01,
        ST_POWER_UP = 5'h02,
        ST_RESOURCE_ON = 5'h04,
        ST_LEAD = 5'h08,
        ST_POWER_DOWN = 5'h10
    } power_state_e;

endpackage

// ==== rtl/onkey_debounce.sv ====
// debounces the synchronised on-key level
// assumes input already passed two flip-flops
`timescale 1ns/1ps
module onkey_debounce #(
    parameter int unsigned SHORT_CYC = supervisor_pkg::DEBOUNCE_SHORT_CYC,
    parameter int unsigned LONG_CYC = supervisor_pkg::DEBOUNCE_LONG_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic long_sel,
    input wire logic raw,
    output logic stable
);
    import supervisor_pkg::*;

    logic [31:0] count;
    wire [31:0] limit = long_sel ? LONG_CYC : SHORT_CYC;
    wire differs = raw != stable;
    wire settled = differs && (count >= limit - 32'h1);

    // R09 debounce interval
    always_ff @(posedge clk) begin
        if (srst) begin
            count <= 32'h0;
            stable <= 1'b1;
        end else if (!differs) begin
            count <= 32'h0;
        end else if (settled) begin
            count <= 32'h0;
            stable <= raw;
        end else begin
            count <= count + 32'h1;
        end
    end
endmodule

// ==== rtl/pmic_global_supervisor.sv ====
// global supervisor: supply monitors, thermal, on-key, interrupt and reset pins
// assumes comparator and pin inputs are asynchronous; single clock clk
//
// Behaviour
// R01 - hold internal reset while supply below threshold
// R02 - flag undervoltage to the top controller
// R03 - inhibit regulators during overvoltage lock
// R04 - two thermal alarms with maskable rising interrupts
// R05 - shutdown temperature sets flag and powers off
// R06 - shutdown flag survives re-enable for software
// R07 - software unmasks alarms and reacts to them
// R08 - readable chip option identifier
// R09 - active-low on-key debounced, selectable interval
// R10 - maskable rise and fall on-key interrupts
// R11 - decode behaviour: push, slide, logic
// R12 - falling edge powers up in push/slide
// R13 - manual reset only in resource-on state
// R14 - push hold low powers down to shutdown
// R15 - slide hold high powers down to standby
// R16 - logic level powers up and down directly
// R17 - behaviour resets to push-button
// R18 - pullup strength: zero strong, one weak
// R19 - interrupt pin low on pending unmasked bit
// R20 - masks reset masked, masked bits ignored
// R21 - reset pin releases after last regulator plus delay
// R22 - reset pin asserts ahead of first disable
// R23 - flags latch, clear on read, mask-independent
`timescale 1ns/1ps
module pmic_global_supervisor #(
    parameter int unsigned DEBOUNCE_SHORT = supervisor_pkg::DEBOUNCE_SHORT_CYC,
    parameter int unsigned DEBOUNCE_LONG = supervisor_pkg::DEBOUNCE_LONG_CYC,
    parameter longint unsigned HOLD_SHORT = supervisor_pkg::HOLD_SHORT_CYC,
    parameter longint unsigned HOLD_LONG = supervisor_pkg::HOLD_LONG_CYC,
    parameter int unsigned RELEASE_DELAY = supervisor_pkg::RELEASE_DELAY_CYC,
    parameter int unsigned ASSERT_LEAD = supervisor_pkg::ASSERT_LEAD_CYC,
    // arbitrary option code
    parameter logic [4:0] CHIP_OPTION = supervisor_pkg::CHIP_OPTION_DEFAULT
) (
    input wire logic clk,
    input wire logic srst,
    input wire supervisor_pkg::supply_s supply_raw,
    input wire supervisor_pkg::thermal_s thermal_raw,
    input wire logic on_key_n,
    input wire logic [1:0] onkey_behaviour_select,
    input wire logic onkey_debounce_select,
    input wire logic manual_reset_hold_time,
    input wire logic weak_pullup_select_in,
    input wire logic [3:0] int_mask_wdata,
    input wire logic int_mask_write,
    input wire logic behaviour_write,
    input wire logic int_read,
    input wire logic event_read,
    input wire logic regulators_up_done,
    input wire logic regulators_down_done,
    output logic supply_por_reset,
    output logic supply_undervoltage,
    output logic supply_overvoltage_lock,
    output logic regulator_inhibit,
    output logic [4:0] chip_option_id,
    output logic [3:0] int_flags,
    output logic [3:0] int_mask,
    output logic [2:0] thermal_status,
    output logic thermal_shutdown_flag,
    output logic [1:0] behaviour_active,
    output logic weak_pullup_select,
    output logic onkey_level,
    output logic power_up_start,
    output logic power_down_start,
    output logic standby_target,
    output logic regulators_enable,
    output logic irq_out_n_o,
    output logic irq_out_n_oe,
    output logic reset_out_n_o,
    output logic reset_out_n_oe
);
    import supervisor_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [7:0] sync1;
    logic [7:0] sync2;
    wire [7:0] async_in = {on_key_n, supply_raw, thermal_raw, 1'b0};
    always_ff @(posedge clk) begin
        sync1 <= async_in;
        sync2 <= sync1;
    end
    wire key_sync = sync2[7];
    wire por_s = sync2[6];
    wire uv_s = sync2[5];
    wire ov_s = sync2[4];
    wire hot1 = sync2[3];
    wire hot2 = sync2[2];
    wire hot_sd = sync2[1];

    // ****************************************
    // supply monitors
    // ****************************************
    // R01 por reset hold
    wire int_rst = srst | por_s;
    // R02 undervoltage out
    assign supply_undervoltage = uv_s;
    assign supply_por_reset = por_s;
    // R03 overvoltage inhibit
    assign supply_overvoltage_lock = ov_s;
    assign regulator_inhibit = ov_s | uv_s;
    // R08 option id
    assign chip_option_id = CHIP_OPTION;

    // ****************************************
    // configuration
    // ****************************************
    logic [1:0] behaviour;
    logic pullup_weak;
    always_ff @(posedge clk) begin
        // R17 behaviour reset
        if (int_rst) begin
            behaviour <= BEHAVIOUR_RESET;
            pullup_weak <= 1'b0;
        end else begin
            pullup_weak <= weak_pullup_select_in;
            if (behaviour_write && onkey_behaviour_select != 2'h3) begin
                behaviour <= onkey_behaviour_select;
            end
        end
    end
    // R18 pullup strength
    assign weak_pullup_select = pullup_weak;
    assign behaviour_active = behaviour;
    // R11 behaviour decode
    wire is_push = behaviour == BEHAVIOUR_PUSH;
    wire is_slide = behaviour == BEHAVIOUR_SLIDE;
    wire is_logic = behaviour == BEHAVIOUR_LOGIC;

    // ****************************************
    // on-key debounce and edges
    // ****************************************
    logic key_db;
    logic key_db_d;
    onkey_debounce #(
        .SHORT_CYC(DEBOUNCE_SHORT),
        .LONG_CYC(DEBOUNCE_LONG)
    ) u_debounce (
        .clk(clk),
        .srst(int_rst),
        .long_sel(onkey_debounce_select),
        .raw(key_sync),
        .stable(key_db)
    );
    always_ff @(posedge clk) begin
        if (int_rst) begin
            key_db_d <= 1'b1;
        end else begin
            key_db_d <= key_db;
        end
    end
    wire key_rise = key_db & ~key_db_d;
    wire key_fall = ~key_db & key_db_d;
    assign onkey_level = key_db;

    // ****************************************
    // thermal alarms
    // ****************************************
    logic [2:0] hot_d;
    logic tsd_flag;
    always_ff @(posedge clk) begin
        if (int_rst) begin
            hot_d <= 3'h0;
        end else begin
            hot_d <= {hot_sd, hot2, hot1};
        end
    end
    wire alarm1_rise = hot1 & ~hot_d[0];
    wire alarm2_rise = hot2 & ~hot_d[1];
    wire tsd_rise = hot_sd & ~hot_d[2];
    assign thermal_status = {hot_sd, hot2, hot1};
    // R06 flag kept over re-enable and por, cleared only by read or srst
    always_ff @(posedge clk) begin
        if (srst) begin
            tsd_flag <= 1'b0;
        end else if (tsd_rise) begin
            tsd_flag <= 1'b1;
        end else if (event_read) begin
            tsd_flag <= 1'b0;
        end
    end
    assign thermal_shutdown_flag = tsd_flag;

    // ****************************************
    // interrupt flags and mask
    // ****************************************
    logic [3:0] flags;
    logic [3:0] mask;
    wire [3:0] events;
    // R04 alarm events
    assign events[INT_ALARM1] = alarm1_rise;
    assign events[INT_ALARM2] = alarm2_rise;
    // R10 key edge events
    assign events[INT_KEY_RISE] = key_rise;
    assign events[INT_KEY_FALL] = key_fall;
    genvar gi;
    generate
        for (gi = 0; gi < INT_COUNT; gi++) begin : g_flag
            // R23 set wins over read clear
            always_ff @(posedge clk) begin
                if (int_rst) begin
                    flags[gi] <= 1'b0;
                end else if (events[gi]) begin
                    flags[gi] <= 1'b1;
                end else if (int_read) begin
                    flags[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    // R20 masks reset masked
    always_ff @(posedge clk) begin
        if (int_rst) begin
            mask <= INT_MASK_RESET;
        end else if (int_mask_write) begin
            mask <= int_mask_wdata;
        end
    end
    assign int_flags = flags;
    assign int_mask = mask;
    // R19 nor of unmasked pending
    wire irq_any = |(flags & ~mask);
    assign irq_out_n_o = 1'b0;
    assign irq_out_n_oe = ~irq_any;

    // ****************************************
    // manual reset hold counter
    // ****************************************
    power_state_e state;
    power_state_e next_state;
    logic [63:0] hold_count;
    logic [31:0] delay_count;
    wire [63:0] hold_limit = manual_reset_hold_time ? HOLD_LONG : HOLD_SHORT;
    // R14 push held low; R15 slide held high
    wire hold_level = (is_push && !key_db) || (is_slide && key_db);
    // R13 only in resource-on
    wire hold_active = hold_level && state == ST_RESOURCE_ON;
    wire hold_done = hold_active && hold_count >= hold_limit - 64'h1;
    always_ff @(posedge clk) begin
        if (int_rst || !hold_active) begin
            hold_count <= 64'h0;
        end else if (!hold_done) begin
            hold_count <= hold_count + 64'h1;
        end
    end

    // ****************************************
    // power state sequence
    // ****************************************
    // R12 falling edge wake
    wire wake_edge = (is_push || is_slide) && key_fall;
    // R16 logic level control
    wire logic_on = is_logic && !key_db;
    wire logic_off = is_logic && key_db;
    // R05 thermal shutdown off
    wire force_off = hot_sd || ov_s || uv_s;
    wire wake = (wake_edge || logic_on) && !regulator_inhibit && !hot_sd;
    wire go_down = hold_done || logic_off || force_off;
    wire lead_done = delay_count >= ASSERT_LEAD - 32'h1;
    wire release_done = delay_count >= RELEASE_DELAY - 32'h1;
    logic standby;
    logic rst_n;

    always_comb begin
        next_state = state;
        case (state)
            ST_SHUTDOWN: begin
                if (wake) begin
                    next_state = ST_POWER_UP;
                end
            end
            ST_POWER_UP: begin
                if (force_off) begin
                    next_state = ST_LEAD;
                end else if (regulators_up_done && release_done) begin
                    next_state = ST_RESOURCE_ON;
                end
            end
            ST_RESOURCE_ON: begin
                if (go_down) begin
                    next_state = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (lead_done) begin
                    next_state = ST_POWER_DOWN;
                end
            end
            ST_POWER_DOWN: begin
                if (regulators_down_done) begin
                    next_state = ST_SHUTDOWN;
                end
            end
            default: begin
                next_state = ST_SHUTDOWN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (int_rst) begin
            state <= ST_SHUTDOWN;
            delay_count <= 32'h0;
            standby <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            state <= next_state;
            // R21 release delay after last regulator
            if (next_state != state) begin
                delay_count <= 32'h0;
            end else if (state == ST_LEAD || (state == ST_POWER_UP && regulators_up_done)) begin
                delay_count <= delay_count + 32'h1;
            end
            rst_n <= next_state == ST_RESOURCE_ON;
            if (state == ST_RESOURCE_ON && next_state == ST_LEAD) begin
                standby <= is_slide && hold_done;
            end
        end
    end

    assign power_up_start = state == ST_SHUTDOWN && next_state == ST_POWER_UP;
    assign power_down_start = state == ST_LEAD && next_state == ST_POWER_DOWN;
    assign standby_target = standby;
    // R22 regulators held through lead
    assign regulators_enable = state == ST_POWER_UP || state == ST_RESOURCE_ON
        || state == ST_LEAD;
    assign reset_out_n_o = 1'b0;
    assign reset_out_n_oe = rst_n;
endmodule

// ==== tb/regulator_pin_model.sv ====
// regulator sequencer and pin pullups beside the supervisor
// assumes one clock; done levels follow enable after four cycles
`timescale 1ns/1ps
module regulator_pin_model (
    input wire logic clk,
    input wire logic regulators_enable,
    input wire logic irq_out_n_o,
    input wire logic irq_out_n_oe,
    input wire logic reset_out_n_o,
    input wire logic reset_out_n_oe,
    output logic regulators_up_done,
    output logic regulators_down_done,
    output logic irq_pin,
    output logic reset_pin
);
    // ****************
    // sequencer and pins
    // ****************
    logic [3:0] hist = 4'h0;
    always @(posedge clk) begin
        hist <= {hist[2:0], regulators_enable};
    end
    assign regulators_up_done = &hist;
    assign regulators_down_done = ~|hist;
    assign irq_pin = irq_out_n_oe ? 1'h1 : irq_out_n_o;
    assign reset_pin = reset_out_n_oe ? 1'h1 : reset_out_n_o;
endmodule

// ==== tb/supervisor_props.sv ====
// port assertions for the global supervisor
// bound to every pmic_global_supervisor instance
`timescale 1ns/1ps
module supervisor_props #(
    parameter int unsigned ASSERT_LEAD = 5,
    parameter int unsigned RELEASE_DELAY = 5,
    parameter logic [4:0] CHIP_OPTION = 5'h0b
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic int_read,
    input wire logic event_read,
    input wire logic regulators_up_done,
    input wire logic supply_por_reset,
    input wire logic supply_undervoltage,
    input wire logic supply_overvoltage_lock,
    input wire logic regulator_inhibit,
    input wire logic [4:0] chip_option_id,
    input wire logic [3:0] int_flags,
    input wire logic [3:0] int_mask,
    input wire logic thermal_shutdown_flag,
    input wire logic [1:0] behaviour_active,
    input wire logic power_up_start,
    input wire logic regulators_enable,
    input wire logic irq_out_n_oe,
    input wire logic reset_out_n_oe
);
    // ****************
    // port relations
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_irq_nor_flags: assert property (irq_out_n_oe == ~|(int_flags & ~int_mask))
        else $error("irq pin disagrees with flags");
    a_reset_state: assert property ($fell(srst) |-> int_mask == 4'hf && int_flags == 4'h0
        && behaviour_active == 2'h0 && !reset_out_n_oe) else $error("bad reset state");
    a_por_clears: assert property (supply_por_reset [*2] |-> int_mask == 4'hf
        && !regulators_enable) else $error("por did not reset");
    a_chip_option: assert property (chip_option_id == CHIP_OPTION)
        else $error("chip option wrong");
    a_inhibit_lock: assert property (regulator_inhibit ==
        (supply_overvoltage_lock | supply_undervoltage)) else $error("inhibit wrong");
    a_release_after_up: assert property ($rose(reset_out_n_oe) |-> regulators_enable
        && $past(regulators_up_done, RELEASE_DELAY)) else $error("reset released early");
    a_assert_before_off: assert property ($fell(regulators_enable) |->
        $past(!reset_out_n_oe, ASSERT_LEAD - 2)) else $error("reset not ahead of disable");
    a_tsd_sticky: assert property (thermal_shutdown_flag && !event_read |=>
        thermal_shutdown_flag) else $error("shutdown flag lost");
    a_flags_latch: assert property (!int_read && !supply_por_reset |=>
        (int_flags & $past(int_flags)) == $past(int_flags)) else $error("flag dropped");
    a_start_pulse: assert property (power_up_start |=> !power_up_start)
        else $error("start not a pulse");
endmodule

bind pmic_global_supervisor supervisor_props #(.ASSERT_LEAD(ASSERT_LEAD),
    .RELEASE_DELAY(RELEASE_DELAY), .CHIP_OPTION(CHIP_OPTION)) u_supervisor_props (
    .clk, .srst, .int_read, .event_read, .regulators_up_done, .supply_por_reset,
    .supply_undervoltage, .supply_overvoltage_lock, .regulator_inhibit, .chip_option_id,
    .int_flags, .int_mask, .thermal_shutdown_flag, .behaviour_active, .power_up_start,
    .regulators_enable, .irq_out_n_oe, .reset_out_n_oe);

// ==== tb/testbench.sv ====
// self-checking bench for the global supervisor
// assumes shortened counts and the regulator pin model
`timescale 1ns/1ps
module testbench;
    import supervisor_pkg::*;
    // ****************
    // wiring
    // ****************
    localparam logic [4:0] CHIP = 5'h15; // arbitrary option code
    logic clk = 1'h0, srst = 1'h1, on_key_n = 1'h1, onkey_debounce_select = 1'h0;
    logic manual_reset_hold_time = 1'h0, weak_pullup_select_in = 1'h0, int_mask_write = 1'h0;
    logic behaviour_write = 1'h0, int_read = 1'h0, event_read = 1'h0;
    logic [1:0] onkey_behaviour_select = 2'h0;
    logic [3:0] int_mask_wdata = 4'h0;
    supply_s supply_raw = '0;
    thermal_s thermal_raw = '0;
    logic regulators_up_done, regulators_down_done, supply_por_reset, supply_undervoltage;
    logic supply_overvoltage_lock, regulator_inhibit, thermal_shutdown_flag, weak_pullup_select;
    logic onkey_level, power_up_start, power_down_start, standby_target, regulators_enable;
    logic irq_out_n_o, irq_out_n_oe, reset_out_n_o, reset_out_n_oe, irq_pin, reset_pin;
    logic [4:0] chip_option_id;
    logic [3:0] int_flags, int_mask;
    logic [2:0] thermal_status;
    logic [1:0] behaviour_active;
    int err_count = 0, cmp_count = 0, n;
    pmic_global_supervisor #(.DEBOUNCE_SHORT(10), .DEBOUNCE_LONG(40), .HOLD_SHORT(100),
        .HOLD_LONG(200), .RELEASE_DELAY(5), .ASSERT_LEAD(5), .CHIP_OPTION(CHIP))
        u_pmic_global_supervisor (.clk, .srst, .supply_raw, .thermal_raw, .on_key_n,
        .onkey_behaviour_select, .onkey_debounce_select, .manual_reset_hold_time,
        .weak_pullup_select_in, .int_mask_wdata, .int_mask_write, .behaviour_write, .int_read,
        .event_read, .regulators_up_done, .regulators_down_done, .supply_por_reset,
        .supply_undervoltage, .supply_overvoltage_lock, .regulator_inhibit, .chip_option_id,
        .int_flags, .int_mask, .thermal_status, .thermal_shutdown_flag, .behaviour_active,
        .weak_pullup_select, .onkey_level, .power_up_start, .power_down_start, .standby_target,
        .regulators_enable, .irq_out_n_o, .irq_out_n_oe, .reset_out_n_o, .reset_out_n_oe);
    regulator_pin_model u_regulator_pin_model (.clk, .regulators_enable, .irq_out_n_o,
        .irq_out_n_oe, .reset_out_n_o, .reset_out_n_oe, .regulators_up_done,
        .regulators_down_done, .irq_pin, .reset_pin);
    // ****************
    // helpers
    // ****************
    initial begin
        forever #2.5 clk = ~clk;
    end
    task test_done;
        $display("compares %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task key(input logic v);
        @(posedge clk);
        on_key_n <= v;
    endtask
    task wr_mask(input logic [3:0] m);
        @(posedge clk);
        int_mask_wdata <= m;
        int_mask_write <= 1'h1;
        @(posedge clk);
        int_mask_write <= 1'h0;
    endtask
    task wr_beh(input logic [1:0] b);
        @(posedge clk);
        onkey_behaviour_select <= b;
        behaviour_write <= 1'h1;
        @(posedge clk);
        behaviour_write <= 1'h0;
    endtask
    task rd_int;
        @(posedge clk);
        int_read <= 1'h1;
        @(posedge clk);
        int_read <= 1'h0;
    endtask
    task wait_up;
        for (n = 0; n < 200 && reset_pin !== 1'h1; n++) tick(1);
    endtask
    task wait_down(input int lim);
        for (n = 0; n < lim && power_down_start !== 1'h1; n++) tick(1);
    endtask
    task wait_off;
        for (n = 0; n < 200 && regulators_enable !== 1'h0; n++) tick(1);
    endtask
    // ****************
    // scenarios
    // ****************
    task t_reset;
        chk(reset_pin, 1'h0);
        chk(irq_pin, 1'h1);
        chk(int_mask, 4'hf);
        chk(behaviour_active, BEHAVIOUR_RESET);
        chk(chip_option_id, CHIP);
        @(posedge clk);
        weak_pullup_select_in <= 1'h1;
        wr_beh(2'h3);
        tick(3);
        chk(weak_pullup_select, 1'h1);
        chk(behaviour_active, BEHAVIOUR_PUSH);
    endtask
    task t_supply;
        @(posedge clk);
        supply_raw.overvoltage <= 1'h1;
        tick(4);
        chk({supply_overvoltage_lock, regulator_inhibit}, 2'h3);
        @(posedge clk);
        supply_raw <= '{por: 1'h0, undervoltage: 1'h1, overvoltage: 1'h0};
        tick(4);
        chk({supply_undervoltage, regulator_inhibit}, 2'h3);
        wr_mask(4'h0);
        supply_raw <= '{por: 1'h1, undervoltage: 1'h0, overvoltage: 1'h0};
        tick(5);
        chk({supply_por_reset, int_mask}, 5'h1f);
        @(posedge clk);
        supply_raw <= '0;
        tick(5);
    endtask
    task t_thermal;
        wr_mask(4'he);
        thermal_raw.alarm2_hot <= 1'h1;
        tick(5);
        chk({int_flags[INT_ALARM2], irq_pin}, 2'h3);
        @(posedge clk);
        thermal_raw.alarm1_hot <= 1'h1;
        tick(5);
        chk(irq_pin, 1'h0);
        chk(thermal_status, 3'h3);
        rd_int;
        tick(1);
        chk({int_flags, irq_pin}, 5'h01);
        @(posedge clk);
        thermal_raw <= '0;
        tick(5);
        chk(int_flags, 4'h0);
    endtask
    task t_push;
        wr_mask(4'h7);
        onkey_debounce_select <= 1'h1;
        key(1'h0);
        for (n = 0; n < 60 && power_up_start !== 1'h1; n++) tick(1);
        chk(n >= 40, 1'h1);
        chk(power_up_start, 1'h1);
        tick(1);
        chk({int_flags[INT_KEY_FALL], irq_pin, reset_pin}, 3'h4);
        chk(onkey_level, 1'h0);
        wait_up;
        chk(regulators_enable, 1'h1);
        wait_down(400);
        chk({reset_pin, standby_target}, 2'h0);
        chk(n >= 90 && n < 150, 1'h1);
        wait_off;
        key(1'h1);
        onkey_debounce_select <= 1'h0;
        tick(30);
        rd_int;
    endtask
    task t_slide;
        wr_beh(BEHAVIOUR_SLIDE);
        manual_reset_hold_time <= 1'h1;
        key(1'h0);
        wait_up;
        chk(reset_pin, 1'h1);
        key(1'h1);
        wait_down(600);
        chk(n >= 190, 1'h1);
        tick(1);
        chk(standby_target, 1'h1);
        wait_off;
    endtask
    task t_logic;
        wr_beh(BEHAVIOUR_LOGIC);
        tick(1);
        chk(behaviour_active, BEHAVIOUR_LOGIC);
        key(1'h0);
        wait_up;
        chk(reset_pin, 1'h1);
        key(1'h1);
        wait_down(100);
        chk(n < 50, 1'h1);
        wait_off;
    endtask
    task t_tsd;
        key(1'h0);
        wait_up;
        @(posedge clk);
        thermal_raw.shutdown_hot <= 1'h1;
        wait_down(100);
        chk(power_down_start, 1'h1);
        wait_off;
        chk(thermal_shutdown_flag, 1'h1);
        @(posedge clk);
        thermal_raw <= '0;
        key(1'h1);
        tick(30);
        key(1'h0);
        wait_up;
        chk({thermal_shutdown_flag, reset_pin}, 2'h3);
        @(posedge clk);
        event_read <= 1'h1;
        @(posedge clk);
        event_read <= 1'h0;
        tick(1);
        chk(thermal_shutdown_flag, 1'h0);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'h0;
        tick(3);
        t_reset;
        t_supply;
        t_thermal;
        t_push;
        t_slide;
        t_logic;
        t_tsd;
        test_done;
    end
    initial begin
        #50000;
        err_count++;
        test_done;
    end
endmodule
